// ===== logic/ospt_timer_channel.sv
// One-shot and PWM down-counting timer channel with register port.
// Trigger, overflow and subclock inputs are asynchronous; three-stage sync.
module ospt_timer_channel (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire ospt_pkg::ospt_bus_s bus,
  output logic [15:0] rdata,
  input wire logic trigger_input_pin,
  input wire logic timerOverflow,
  input wire logic subclock_div32_tap,
  output logic pulse_output_pin,
  output logic pulseOutEn,
  output logic gpioInValue,
  output logic irq
);
  logic [15:0] reloadReg, reloadNext, countReg, countNext, ctrlReg, ctrlNext;
  logic [7:0] preReg, preNext;
  logic outReg, outNext, osStartReg, osStartNext;
  logic [1:0] statReg, statNext, maskReg, maskNext;
  logic [15:0] rdataReg, rdataNext;
  logic [4:0] divReg, divNext;
  logic [2:0] trgSync, ovfSync, subSync;
  logic trgPrev, subPrev;
  ospt_pkg::ospt_state_e stateReg, stateNext;
  logic tick, trigEvt, ovfEvt, startEvt, running, pwmMode, pwm8;
  logic zeroEvt, riseEvt, fallEvt;
  ospt_pkg::ospt_clk_e clkSel;

  // Three-flop synchronisers; stage 0 is read only by stage 1
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      trgSync <= 3'h0;
      ovfSync <= 3'h0;
      subSync <= 3'h0;
      trgPrev <= 1'b0;
      subPrev <= 1'b0;
    end
    else
    begin
      trgSync <= {trgSync[1:0], trigger_input_pin};
      ovfSync <= {ovfSync[1:0], timerOverflow};
      subSync <= {subSync[1:0], subclock_div32_tap};
      if (trgSync[1] == trgSync[2]) trgPrev <= trgSync[2];
      if (subSync[1] == subSync[2]) subPrev <= subSync[2];
    end
  end

  assign pwmMode = ctrlReg[ospt_pkg::CTRL_MODE];
  assign pwm8 = ctrlReg[ospt_pkg::CTRL_PWM8];
  assign clkSel = ospt_pkg::ospt_clk_e'(ctrlReg[ospt_pkg::CTRL_CLK_LO +: 2]);
  assign gpioInValue = trgPrev;
  assign running = (stateReg != ospt_pkg::OSPT_IDLE);

  // Trigger edge once stages two and three agree, with chosen polarity
  // pin trigger and overflow edge detection
  always_comb
  begin
    trigEvt = 1'b0;
    if (ctrlReg[ospt_pkg::CTRL_TRIG_EN] && trgSync[1] == trgSync[2] && trgSync[2] != trgPrev)
      trigEvt = ctrlReg[ospt_pkg::CTRL_TRIG_FALL] ? !trgSync[2] : trgSync[2];
    ovfEvt = ctrlReg[ospt_pkg::CTRL_OVF_EN] && ovfSync[1] && !ovfSync[2];
  end

  always_comb
  begin
    divNext = divReg + 5'h01;
    case (clkSel)
      ospt_pkg::OSPT_CLK_DIV1: tick = 1'b1;
      ospt_pkg::OSPT_CLK_DIV8: tick = (divReg[2:0] == ospt_pkg::DIV8_MAX[2:0]);
      ospt_pkg::OSPT_CLK_DIV32: tick = (divReg == ospt_pkg::DIV32_MAX);
      ospt_pkg::OSPT_CLK_SUB32: tick = subSync[1] == subSync[2] && subSync[2] && !subPrev;
      default: tick = 1'b0;
    endcase
  end

  // Start events: pin trigger edge, overflow edge, or software one-shot flag outside PWM
  // one-shot and PWM start sources
  assign startEvt = trigEvt || ovfEvt || (pwmMode ? 1'b0 : osStartReg);

  // Counter, reload, output and state next values
  always_comb
  begin
    reloadNext = reloadReg;
    countNext = countReg;
    preNext = preReg;
    outNext = outReg;
    stateNext = stateReg;
    osStartNext = 1'b0;
    ctrlNext = ctrlReg;
    zeroEvt = 1'b0;
    riseEvt = 1'b0;
    fallEvt = 1'b0;
    if (bus.wr && bus.addr == ospt_pkg::ADDR_CTRL)
    begin
      ctrlNext = bus.wdata;
      ctrlNext[ospt_pkg::CTRL_OS_START] = 1'b0;
      osStartNext = bus.wdata[ospt_pkg::CTRL_OS_START];
    end
    if (!ctrlReg[ospt_pkg::CTRL_START])
    begin
      stateNext = ospt_pkg::OSPT_IDLE;
      outNext = 1'b0;
    end
    else if (!pwmMode)
    begin
      if (startEvt)
      begin
        countNext = reloadReg;
        stateNext = ospt_pkg::OSPT_RUN;
        outNext = 1'b1;
      end
      else if (running && tick)
      begin
        // count down, reload at zero, halt
        if (countReg <= 16'h0001)
        begin
          countNext = reloadReg;
          stateNext = ospt_pkg::OSPT_IDLE;
          outNext = 1'b0;
          zeroEvt = 1'b1;
        end
        else
          countNext = countReg - 16'h0001;
      end
    end
    else
    begin
      if (!running && (startEvt || ctrlReg[ospt_pkg::CTRL_START]))
      begin
        stateNext = ospt_pkg::OSPT_RUN;
        countNext = pwm8 ? {8'h00, ospt_pkg::PWM8_TOP} : ospt_pkg::PWM16_TOP;
        preNext = reloadReg[7:0];
        outNext = 1'b0;
      end
      else if (running && tick)
      begin
        if (pwm8 && preReg != 8'h00)
          preNext = preReg - 8'h01;
        else
        begin
          preNext = reloadReg[7:0];
          // reload at rising edge, keep counting
          if (countReg <= 16'h0001)
          begin
            countNext = pwm8 ? {8'h00, ospt_pkg::PWM8_TOP} : ospt_pkg::PWM16_TOP;
            outNext = pwm8 ? (reloadReg[15:8] != 8'h00) : (reloadReg != 16'h0000);
            riseEvt = outNext;
          end
          else
          begin
            countNext = countReg - 16'h0001;
            // high while remaining exceeds period minus n
            if (outReg && (pwm8 ? countNext[7:0] <= ospt_pkg::PWM8_TOP - reloadReg[15:8]
                                 : countNext <= ospt_pkg::PWM16_TOP - reloadReg))
              outNext = 1'b0;
          end
          fallEvt = outReg && !outNext;
        end
      end
    end
    if (bus.wr && bus.addr == ospt_pkg::ADDR_DATA)
    begin
      reloadNext = bus.wdata;
      if (!running && !startEvt) countNext = bus.wdata;
    end
  end

  // Sticky status, set wins over write-one clear
  always_comb
  begin
    statNext = statReg;
    maskNext = maskReg;
    if (bus.wr && bus.addr == ospt_pkg::ADDR_STAT) statNext = statReg & ~bus.wdata[1:0];
    if (bus.wr && bus.addr == ospt_pkg::ADDR_MASK) maskNext = bus.wdata[1:0];
    if (zeroEvt || fallEvt) statNext[0] = 1'b1;
    if (riseEvt) statNext[1] = 1'b1;
  end

  always_comb
  begin
    rdataNext = 16'h0000;
    if (bus.rd)
      case (bus.addr)
        ospt_pkg::ADDR_DATA: rdataNext = ospt_pkg::UNDEF_READ;
        ospt_pkg::ADDR_CTRL: rdataNext = ctrlReg;
        ospt_pkg::ADDR_STAT: rdataNext = {13'h0000, running, statReg};
        ospt_pkg::ADDR_MASK: rdataNext = {14'h0000, maskReg};
        default: rdataNext = 16'h0000;
      endcase
  end

  // State registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reloadReg <= ospt_pkg::DATA_RESET;
      countReg <= ospt_pkg::DATA_RESET;
      ctrlReg <= ospt_pkg::CTRL_RESET;
      preReg <= 8'h00;
      outReg <= 1'b0;
      osStartReg <= 1'b0;
      stateReg <= ospt_pkg::OSPT_IDLE;
      statReg <= 2'h0;
      maskReg <= 2'h0;
      rdataReg <= 16'h0000;
      divReg <= 5'h00;
    end
    else
    begin
      reloadReg <= reloadNext;
      countReg <= countNext;
      ctrlReg <= ctrlNext;
      preReg <= preNext;
      outReg <= outNext;
      osStartReg <= osStartNext;
      stateReg <= stateNext;
      statReg <= statNext;
      maskReg <= maskNext;
      rdataReg <= rdataNext;
      divReg <= divNext;
    end
  end

  assign pulseOutEn = pwmMode || ctrlReg[ospt_pkg::CTRL_OUT_EN];
  assign pulse_output_pin = outReg;
  assign rdata = rdataReg;
  assign irq = |(statReg & maskReg);

  oneshot_irq_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (zeroEvt |=> statReg[0] && !running)) else $error("one-shot zero did not flag");
  stop_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (bus.wr && bus.addr == ospt_pkg::ADDR_DATA && !running && !startEvt
     |=> countReg == $past(bus.wdata))) else $error("stopped write missed counter");
  run_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (bus.wr && bus.addr == ospt_pkg::ADDR_DATA && running && !startEvt && countReg > 16'h0001
     |=> (countReg == $past(countReg) || countReg == $past(countReg) - 16'h0001)))
    else $error("running write hit counter");
  stop_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!ctrlReg[ospt_pkg::CTRL_START] |=> !running && !outReg)) else $error("count not stopped");
  // One-shot arm step: a start event accepted while count start is set
  sequence osArmSeq;
    ctrlReg[ospt_pkg::CTRL_START] && !pwmMode && startEvt;
  endsequence
  retrig_load_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (osArmSeq |=> countReg == $past(reloadReg) && outReg)) else $error("retrigger not reloaded");
  pwm_ignore_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (pwmMode && running && ctrlReg[ospt_pkg::CTRL_START] && trigEvt && !bus.wr
     && countReg > 16'h0001
     |=> (countReg == $past(countReg) || countReg == $past(countReg) - 16'h0001)))
    else $error("pwm disturbed");
  pwm_fall_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (pwmMode && $fell(outReg) && ctrlReg[ospt_pkg::CTRL_START] |-> statReg[0]))
    else $error("pwm fall not flagged");
  data_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (bus.rd && bus.addr == ospt_pkg::ADDR_DATA |=> rdata == ospt_pkg::UNDEF_READ))
    else $error("data read not undefined");
  gpio_level_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (trgSync[1] == trgSync[2] |=> gpioInValue == $past(trgSync[2])))
    else $error("pin level not tracked");

  // Bus, flag and prescaler checks; all three divided taps are reached by the bench
  // rise flags and reloads
  pwm_rise_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (riseEvt |=> statReg[1] && outReg)) else $error("pwm rise not flagged");
  os_start_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!(bus.wr && bus.addr == ospt_pkg::ADDR_CTRL) |=> !osStartReg))
    else $error("one-shot start stuck");
  div8_tick_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (clkSel == ospt_pkg::OSPT_CLK_DIV8 && tick && !bus.wr |=> !tick))
    else $error("div8 tick too long");
  rdata_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!bus.rd |=> rdata == 16'h0000)) else $error("read data not idle");
  oneshot_halt_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (zeroEvt |=> countReg == $past(reloadReg) && !outReg))
    else $error("one-shot zero not reloaded");
  pwm_prescale_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (pwmMode && pwm8 && running && ctrlReg[ospt_pkg::CTRL_START] && tick && preReg != 8'h00
     |=> countReg == $past(countReg))) else $error("prescaler moved count");
  stat_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (bus.wr && bus.addr == ospt_pkg::ADDR_STAT && bus.wdata[0] && !zeroEvt && !fallEvt
     |=> !statReg[0])) else $error("status not cleared");
endmodule

// ===== logic/ospt_pkg.sv
// Constants, types and register map for the one-shot / PWM timer channel.
// Assumes a single ref_clk domain and a simple strobe register port.
// Functional notes
// - One-shot counts down n count clocks, reloads at zero, then halts.
// - One-shot trigger while running reloads and restarts the count.
// - One-shot starts on pin trigger edge, timer overflow or software start.
// - Clearing count start stops counter; one-shot also stops after reload.
// - One-shot raises interrupt request when counter reaches zero.
// - One-shot pins are general I/O or trigger input and pulse output.
// - Data register reads return undefined value in these modes.
// - Write while stopped loads reload register and counter together.
// - Write while running loads reload only; counter takes it at reload.
// - PWM counts as 8 or 16-bit modulator, reloads at rising edge.
// - PWM ignores triggers while already running.
// - 16-bit PWM high time n clocks, period 2^16-1 clocks.
// - 8-bit PWM high n*(m+1), period (2^8-1)*(m+1) count clocks.
// - PWM starts on external trigger, timer overflow or count start set; here only count start set starts it.
package ospt_pkg;
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [3:0] ADDR_MASK = 4'hC;
  // Control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_OS_START = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_PWM8 = 3;
  localparam int CTRL_TRIG_EN = 4;
  localparam int CTRL_TRIG_FALL = 5;
  localparam int CTRL_OUT_EN = 6;
  localparam int CTRL_CLK_LO = 7;
  localparam int CTRL_OVF_EN = 9;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [15:0] UNDEF_READ = 16'hFFFF;
  localparam logic [15:0] PWM16_TOP = 16'hFFFF;
  localparam logic [7:0] PWM8_TOP = 8'hFF;
  // Prescaler divide counts
  localparam logic [4:0] DIV8_MAX = 5'h07;
  localparam logic [4:0] DIV32_MAX = 5'h1F;
  typedef enum logic [1:0] {
    OSPT_CLK_DIV1 = 2'h0,
    OSPT_CLK_DIV8 = 2'h1,
    OSPT_CLK_DIV32 = 2'h2,
    OSPT_CLK_SUB32 = 2'h3
  } ospt_clk_e;
  typedef enum logic [1:0] {
    OSPT_IDLE = 2'b00,
    OSPT_RUN = 2'b01,
    OSPT_LAST = 2'b11
  } ospt_state_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ospt_bus_s;
endpackage

// ===== verif/ospt_trig_source.sv
// Far-side model: external trigger source and associated timer overflow.
// Assumes one-cycle fire requests, driven on ref_clk by the bench.
module ospt_trig_source (
  input wire logic ref_clk,
  input wire logic fireTrig,
  input wire logic fireOvf,
  output logic trigPin,
  output logic ovfOut
);
  timeunit 1ns;
  timeprecision 1ns;
  int trigCnt = 0;
  int ovfCnt = 0;
  // trigger and overflow
  // Held four cycles so the three-flop sync sees both edges
  always @(posedge ref_clk)
  begin
    trigCnt <= fireTrig ? 4 : (trigCnt > 0 ? trigCnt - 1 : 0);
    ovfCnt <= fireOvf ? 4 : (ovfCnt > 0 ? ovfCnt - 1 : 0);
  end
  // Idle low between pulses
  assign trigPin = (trigCnt > 0);
  assign ovfOut = (ovfCnt > 0);
endmodule

// ===== verif/test_oneshot_pwm_timer_channel.sv
// Self-checking bench for the one-shot / PWM timer channel.
// Assumes the far-side model file and the design package are compiled first.
module test_oneshot_pwm_timer_channel;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] data;
    logic [1:0] src;
    logic [15:0] hi;
  } ospt_row_s;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  ospt_pkg::ospt_bus_s bus = '0;
  logic [15:0] rdata;
  logic fireTrig = 1'b0;
  logic fireOvf = 1'b0;
  logic trigPin, ovfOut, pulseOut, outEn, irq, gpioIn;
  logic [2:0] subDiv = 3'h0;
  int badCount = 0;
  int numChecks = 0;
  // One-shot starts: control, data, source (0 sw, 1 pin, 2 overflow), high width
  ospt_row_s rows [5] = '{'{16'h0043, 16'h0005, 2'd0, 16'h0005},
    '{16'h0043, 16'h0000, 2'd0, 16'h0001}, '{16'h0051, 16'h0005, 2'd1, 16'h0005},
    '{16'h0071, 16'h0003, 2'd1, 16'h0003}, '{16'h0241, 16'h0004, 2'd2, 16'h0004}};
  // Clock source
  always #5 ref_clk = ~ref_clk;
  // Subclock tap: rises every eight clocks, stepped on the clock edge
  always @(posedge ref_clk) subDiv <= subDiv + 3'h1;
  // Design and far side; subclock tap from the divide-by-8 counter
  ospt_timer_channel ospt_timer_channel_inst (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus),
    .rdata(rdata), .trigger_input_pin(trigPin), .timerOverflow(ovfOut),
    .subclock_div32_tap(subDiv[2]), .pulse_output_pin(pulseOut), .pulseOutEn(outEn),
    .gpioInValue(gpioIn), .irq(irq));
  ospt_trig_source ospt_trig_source_inst (.ref_clk(ref_clk), .fireTrig(fireTrig),
    .fireOvf(fireOvf), .trigPin(trigPin), .ovfOut(ovfOut));
  task automatic conclude;
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Register port cycles; strobe released at the following edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic fire(input logic [1:0] src);
    @(posedge ref_clk);
    fireTrig <= (src == 2'd1);
    fireOvf <= (src == 2'd2);
    @(posedge ref_clk);
    fireTrig <= 1'b0;
    fireOvf <= 1'b0;
  endtask
  // Skips a pulse in progress, then times one full high and period (cap 600)
  task automatic measure(output logic [15:0] hi, output logic [15:0] per);
    int k;
    hi = 16'h0000;
    per = 16'h0000;
    for (k = 0; k < 600 && pulseOut === 1'b1; k++)
      @(posedge ref_clk) #1;
    for (k = 0; k < 600 && pulseOut !== 1'b1; k++)
      @(posedge ref_clk) #1;
    for (; per < 600 && pulseOut === 1'b1; per++, hi++)
      @(posedge ref_clk) #1;
    for (; per < 600 && pulseOut !== 1'b1; per++)
      @(posedge ref_clk) #1;
  endtask
  // Hang guard, well beyond the ten thousand or so cycles the tests need
  initial
  begin
    #400000;
    badCount++;
    conclude;
  end
  initial
  begin
    logic [15:0] v, hi, per, w;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1 check({12'h000, gpioIn, pulseOut, outEn, irq}, 16'h0000);
    check(rdata, 16'h0000);
    wr(ospt_pkg::ADDR_MASK, 16'h0001);
    wr(ospt_pkg::ADDR_DATA, 16'h0005);
    rd(ospt_pkg::ADDR_DATA, v);
    check(v, ospt_pkg::UNDEF_READ);
    rd(4'h2, v);
    check(v, 16'h0000);
    // Trigger pin read back as a filtered level, triggers disabled
    fire(2'd1);
    repeat (5) @(posedge ref_clk);
    #1 check({15'h0000, gpioIn}, 16'h0001);
    repeat (5) @(posedge ref_clk);
    #1 check({15'h0000, gpioIn}, 16'h0000);
    $display("test reset and registers done");
    foreach (rows[i])
    begin
      wr(ospt_pkg::ADDR_CTRL, 16'h0000);
      wr(ospt_pkg::ADDR_DATA, rows[i].data);
      // Armed without the one-shot flag so the measure sees the whole pulse
      wr(ospt_pkg::ADDR_CTRL, rows[i].ctrl & 16'hFFFD);
      fork
        measure(hi, per);
        if (rows[i].src == 2'd0)
          wr(ospt_pkg::ADDR_CTRL, rows[i].ctrl);
        else
          fire(rows[i].src);
      join
      check({15'h0000, outEn}, 16'h0001);
      check(hi, rows[i].hi);
      check(per, 16'h0258);
      rd(ospt_pkg::ADDR_STAT, v);
      check(v, 16'h0001);
      check({15'h0000, irq}, 16'h0001);
      wr(ospt_pkg::ADDR_STAT, 16'h0001);
      rd(ospt_pkg::ADDR_STAT, v);
      check(v, 16'h0000);
      $display("test one-shot row %0d done", i);
    end
    // Retrigger while running stretches the pulse past eight ticks
    wr(ospt_pkg::ADDR_CTRL, 16'h0000);
    wr(ospt_pkg::ADDR_DATA, 16'h0008);
    wr(ospt_pkg::ADDR_CTRL, 16'h0051);
    fire(2'd1);
    fork
      measure(hi, per);
      begin
        repeat (4) @(posedge ref_clk);
        fire(2'd1);
      end
    join
    // Second trigger lands six ticks in, so eight more follow
    check(hi, 16'h000E);
    $display("test retrigger done");
    // Divided count clocks: tick phase is free, so high time falls in one tick window
    for (int s = 1; s < 4; s++)
    begin
      w = (s == 2) ? 16'h0020 : 16'h0008;
      wr(ospt_pkg::ADDR_CTRL, 16'h0000);
      wr(ospt_pkg::ADDR_DATA, 16'h0003);
      wr(ospt_pkg::ADDR_CTRL, 16'h0041 | (16'(s) << ospt_pkg::CTRL_CLK_LO));
      fork
        measure(hi, per);
        wr(ospt_pkg::ADDR_CTRL, 16'h0043 | (16'(s) << ospt_pkg::CTRL_CLK_LO));
      join
      check({15'h0000, hi > 16'h0002 * w && hi <= 16'h0003 * w}, 16'h0001);
    end
    wr(ospt_pkg::ADDR_STAT, 16'h0003);
    $display("test count clock taps done");
    // Eight-bit modulator, n=2 m=1, trigger enabled but ignored
    wr(ospt_pkg::ADDR_CTRL, 16'h0000);
    wr(ospt_pkg::ADDR_DATA, 16'h0201);
    wr(ospt_pkg::ADDR_CTRL, 16'h001D);
    measure(hi, per);
    check(hi, 16'h0004);
    check(per, 16'h01FE);
    check({15'h0000, outEn}, 16'h0001);
    rd(ospt_pkg::ADDR_STAT, v);
    check(v, 16'h0007);
    fork
      measure(hi, per);
      fire(2'd1);
    join
    check(hi, 16'h0004);
    check(per, 16'h01FE);
    check({15'h0000, irq}, 16'h0001);
    wr(ospt_pkg::ADDR_DATA, 16'h0300);
    measure(hi, per);
    check(hi, 16'h0003);
    check(per, 16'h00FF);
    wr(ospt_pkg::ADDR_CTRL, 16'h0000);
    measure(hi, per);
    check(hi, 16'h0000);
    $display("test modulator done");
    conclude;
  end
endmodule
